// ==== ahgc_pkg.sv ====
// shared constants and carriers for the generic host control register bank
package ahgc_pkg;
   // register word offsets (byte addresses within the controller window)
   localparam logic [9:0]  OFS_FEATURE   = 10'h000;
   localparam logic [9:0]  OFS_GCTRL     = 10'h004;
   localparam logic [9:0]  OFS_IRQ_STAT  = 10'h008;
   localparam logic [9:0]  OFS_PORTS_IMP = 10'h00c;
   localparam logic [9:0]  OFS_VERSION   = 10'h010;
   localparam logic [9:0]  OFS_COALESCING_CONTROL   = 10'h014;
   localparam logic [9:0]  OFS_COALESCING_PORT_SELECT = 10'h018;
   localparam logic [9:0]  OFS_ENCLOSURE_MSG_LOCATION    = 10'h01c;
   localparam logic [9:0]  OFS_EM_CTL    = 10'h020;
   localparam logic [9:0]  OFS_VENDOR    = 10'h0a0;
   localparam logic [9:0]  GEN_LAST      = 10'h01f;   // end of generic block
   localparam logic [9:0]  PORT_FIRST    = 10'h100;   // start of port banks
   localparam logic [9:0]  PORT_LAST     = 10'h3ff;   // end of port banks
   localparam int          PORT_BANK_LSB = 7;         // 128-byte banks

   // reset values
   localparam logic [31:0] FEAT_RST_DESK = 32'hff22ffc2;
   localparam logic [31:0] FEAT_RST_MOB  = 32'hde127f03;
   localparam logic [31:0] VERSION_VAL   = 32'h00010200;
   localparam logic [31:0] COALESCING_CONTROL_RST   = 32'h00010121;
   localparam logic [31:0] ENCLOSURE_MSG_LOCATION_VAL    = 32'h01000002;
   localparam logic [31:0] EM_CTL_VAL    = 32'h07010000;
   localparam logic [31:0] ZERO_WORD     = 32'h00000000;

   // feature word: write-once bits and hard fields
   localparam logic [31:0] FEAT_WO_MASK  = 32'h1df060e0;  // 28,27,26,24,23:20,14,13,7,6,5
   localparam int          FEAT_WIDE     = 31;
   localparam int          FEAT_QUEUE    = 30;
   localparam int          FEAT_ALP      = 26;
   localparam int          FEAT_CLO      = 24;
   localparam int          FEAT_ADV_ONLY = 18;
   localparam int          FEAT_NCS_LSB  = 8;
   localparam int          FEAT_NPS_LSB  = 0;
   localparam logic [4:0]  NCS_CODE      = 5'h1f;     // thirty-two slots
   localparam logic [4:0]  NPS_CODE      = 5'h05;     // six ports

   // global control bits
   localparam int          GC_ADV        = 31;
   localparam int          GC_MSI_SINGLE_FALLBACK       = 2;
   localparam int          GC_IRQ_EN     = 1;
   localparam int          GC_SOFT_RST   = 0;

   // interrupt status layout
   localparam int          STAT_CCC      = 6;
   localparam logic [6:0]  STAT_MOB_MASK = 7'h33;     // bits 2,3,6 absent
   localparam logic [6:0]  STAT_DSK_MASK = 7'h7f;
   localparam logic [5:0]  PI_MOB_MASK   = 6'h33;
   localparam logic [5:0]  PI_DSK_MASK   = 6'h3f;
   localparam logic [31:0] COALESCING_CONTROL_RW    = 32'hffffff01;  // bits 7:1 fixed

   // register access request from host memory cycles
   typedef struct packed {
      logic        req;     // access strobe, one cycle
      logic        wr;      // 1 write, 0 read
      logic [9:0]  addr;    // byte address, word aligned
      logic [3:0]  be;      // byte enables
      logic [31:0] wdata;   // write data
   } ahgc_acc_t;

   // register access answer
   typedef struct packed {
      logic        ack;     // one cycle after req
      logic [31:0] rdata;   // read data, zero for writes
   } ahgc_rsp_t;
endpackage : ahgc_pkg

// ==== ahgc_host_control.sv ====
`timescale 1ns/1ps
// Operation
// - function reset restores all non-excluded registers
// - feature word restored to its reset image only by platform reset
// - decode generic block, reserved gap, port banks
// - feature slot count fixed at thirty-two
// - feature port count fixed at six
// - write-once maximum link speed field
// - queue bit one, wide addressing advertised
// - write-once auto link power enable
// - advanced-only bit reflects mode support
// - write-once list override support bit
// - write-once interlock and spin-up bits
// - write-once coalescing, enclosure, external, power bits
// - global enable gates all port interrupts
// - writing one resets controller internals
// - fallback flag tracks msi vector shortage
// - shortage forces single first vector
// - port pending bits, write one clears
// - coalescing pending bit, desktop only
module ahgc_host_control #(
   parameter bit         MOBILE    = 1'b0,  // 1 selects the mobile variant
   parameter bit         ADV_ONLY  = 1'b0,  // 1 when legacy mode is absent
   parameter int         NUM_PORTS = 6      // ports behind this bank
) (
   input  wire logic                clk,
   input  wire logic                sys_rst,
   input  wire logic                platform_reset_n,
   input  wire ahgc_pkg::ahgc_acc_t acc,
   output      ahgc_pkg::ahgc_rsp_t rsp,
   input  wire logic [5:0]          port_irq_event,
   input  wire logic                coalesce_event,
   input  wire logic                msi_on,
   input  wire logic [2:0]          msi_granted_count,
   input  wire logic [2:0]          msi_requested_count,
   output      logic                host_irq,
   output      logic                advanced_mode_on,
   output      logic                controller_soft_reset,
   output      logic                msi_single_fallback,
   output      logic                auto_link_power_en,
   output      logic                list_override_en,
   output      logic [5:0]          ports_implemented,
   output      logic                coalesce_enable,
   output      logic [31:0]         coalesce_ports,
   output      logic                port_bank_hit,
   output      logic [2:0]          port_bank_index
);
   import ahgc_pkg::*;

   // variant dependent constants
   localparam logic [31:0] FEAT_RST  = MOBILE ? FEAT_RST_MOB : FEAT_RST_DESK;
   localparam logic [6:0]  STAT_MASK = MOBILE ? STAT_MOB_MASK : STAT_DSK_MASK;
   localparam logic [5:0]  PI_MASK   = MOBILE ? PI_MOB_MASK : PI_DSK_MASK;

   // storage
   logic [31:0] feat_wo;          // write-once part of feature word
   logic        feat_locked;      // feature word already written once
   logic        pi_locked;        // implemented mask already written once
   logic [5:0]  pi_bits;          // implemented ports
   logic        gc_adv;           // advanced mode selected
   logic        gc_irq_en;        // master interrupt enable
   logic        gc_soft_rst;      // controller reset in progress
   logic        gc_msi_single_fallback;          // single vector fallback flag
   logic [6:0]  pend;             // pending interrupt status
   logic [31:0] coalescing_control;          // coalescing control
   logic [31:0] coalescing_port_select;        // coalescing port select

   // decoded access
   logic        plat_rst;         // platform reset, active high
   logic        flr_rst;          // function level reset or platform reset
   logic [31:0] byte_mask;        // enabled byte lanes
   logic        wr_hit;           // write strobe
   logic [31:0] feat_word;        // assembled feature word
   logic [31:0] next_rdata;       // read mux output
   logic        shortage;         // fewer vectors than requested

   assign plat_rst = ~platform_reset_n;
   assign flr_rst  = sys_rst | plat_rst;
   assign wr_hit   = acc.req & acc.wr;
   assign byte_mask = {{8{acc.be[3]}}, {8{acc.be[2]}}, {8{acc.be[1]}}, {8{acc.be[0]}}};

   // merge write data into a stored word under byte enables
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [31:0] lanes);
      merge = (old_v & ~lanes) | (new_v & lanes);
   endfunction : merge

   // feature word: hard fields placed over the reset image
   always_comb begin
      feat_word = (FEAT_RST & ~FEAT_WO_MASK) | feat_wo;
      feat_word[FEAT_WIDE]    = 1'b1;
      feat_word[FEAT_QUEUE]   = 1'b1;
      feat_word[FEAT_ADV_ONLY] = ADV_ONLY;
      feat_word[FEAT_NCS_LSB +: 5] = NCS_CODE;
      feat_word[FEAT_NPS_LSB +: 5] = NPS_CODE;
   end

   // write-once feature bits, untouched by function level reset
   always_ff @(posedge clk) begin
      if (plat_rst) begin
         feat_wo     <= FEAT_RST & FEAT_WO_MASK;
         feat_locked <= 1'b0;
      end else if (wr_hit && acc.addr == OFS_FEATURE && !feat_locked) begin
         // first write loads speed, power, override, strap bits
         feat_wo     <= merge(feat_wo, acc.wdata, byte_mask) & FEAT_WO_MASK;
         feat_locked <= 1'b1;
      end
   end

   // write-once implemented mask, also kept across function reset
   always_ff @(posedge clk) begin
      if (plat_rst) begin
         pi_bits   <= 6'h00;
         pi_locked <= 1'b0;
      end else if (wr_hit && acc.addr == OFS_PORTS_IMP && !pi_locked) begin
         pi_bits   <= acc.be[0] ? (acc.wdata[5:0] & PI_MASK) : pi_bits;
         pi_locked <= 1'b1;
      end
   end

   // global control: mode select, interrupt enable, controller reset
   always_ff @(posedge clk) begin
      if (flr_rst) begin
         gc_adv      <= 1'b0;
         gc_irq_en   <= 1'b0;
         gc_soft_rst <= 1'b0;
      end else if (gc_soft_rst) begin
         // reset lasts one cycle, then the bit reads back zero
         gc_soft_rst <= 1'b0;
      end else if (wr_hit && acc.addr == OFS_GCTRL) begin
         if (acc.be[3]) begin
            gc_adv <= acc.wdata[GC_ADV];
         end
         if (acc.be[0]) begin
            gc_irq_en   <= acc.wdata[GC_IRQ_EN];
            gc_soft_rst <= acc.wdata[GC_SOFT_RST];
         end
      end
   end

   // vector shortage: msi on, at least one granted, fewer than asked
   assign shortage = msi_on && (msi_granted_count != 3'h0)
                     && (msi_granted_count < msi_requested_count);

   // fallback flag follows the shortage, ignored during controller reset
   always_ff @(posedge clk) begin
      if (flr_rst) begin
         gc_msi_single_fallback <= 1'b0;
      end else begin
         gc_msi_single_fallback <= shortage && !gc_soft_rst;
      end
   end

   // pending status: hardware set wins over a clearing write
   always_ff @(posedge clk) begin
      if (flr_rst || gc_soft_rst) begin
         pend <= 7'h00;
      end else begin
         logic [6:0] clr_bits;
         logic [6:0] set_bits;
         clr_bits = (wr_hit && acc.addr == OFS_IRQ_STAT && acc.be[0])
                    ? acc.wdata[6:0] : 7'h00;
         set_bits = {coalesce_event, port_irq_event};
         pend <= ((pend & ~clr_bits) | set_bits) & STAT_MASK;
      end
   end

   // coalescing control and port select
   always_ff @(posedge clk) begin
      if (flr_rst) begin
         coalescing_control   <= COALESCING_CONTROL_RST;
         coalescing_port_select <= ZERO_WORD;
      end else if (wr_hit && acc.addr == OFS_COALESCING_CONTROL) begin
         coalescing_control <= (merge(coalescing_control, acc.wdata, byte_mask) & COALESCING_CONTROL_RW)
                    | (COALESCING_CONTROL_RST & ~COALESCING_CONTROL_RW);
      end else if (wr_hit && acc.addr == OFS_COALESCING_PORT_SELECT) begin
         coalescing_port_select <= merge(coalescing_port_select, acc.wdata, byte_mask);
      end
   end

   // read decode: generic block, named extras, reserved reads zero
   always_comb begin
      next_rdata = ZERO_WORD;
      case (acc.addr)
         OFS_FEATURE:   next_rdata = feat_word;
         OFS_GCTRL: begin
            next_rdata[GC_ADV]      = gc_adv;
            next_rdata[GC_MSI_SINGLE_FALLBACK]     = gc_msi_single_fallback;
            next_rdata[GC_IRQ_EN]   = gc_irq_en;
            next_rdata[GC_SOFT_RST] = gc_soft_rst;
         end
         OFS_IRQ_STAT:  next_rdata[6:0] = pend;
         OFS_PORTS_IMP: next_rdata[5:0] = pi_bits;
         OFS_VERSION:   next_rdata = VERSION_VAL;
         OFS_COALESCING_CONTROL:   next_rdata = coalescing_control;
         OFS_COALESCING_PORT_SELECT: next_rdata = coalescing_port_select;
         OFS_ENCLOSURE_MSG_LOCATION:    next_rdata = ENCLOSURE_MSG_LOCATION_VAL;
         OFS_EM_CTL:    next_rdata = EM_CTL_VAL;
         OFS_VENDOR:    next_rdata = ZERO_WORD;
         default:       next_rdata = ZERO_WORD;
      endcase
   end

   // answer one cycle after each request
   always_ff @(posedge clk) begin
      if (flr_rst) begin
         rsp <= '0;
      end else begin
         rsp.ack   <= acc.req;
         rsp.rdata <= (acc.req && !acc.wr) ? next_rdata : ZERO_WORD;
      end
   end

   // port bank decode, passed on to the per-port logic
   always_ff @(posedge clk) begin
      if (flr_rst) begin
         port_bank_hit   <= 1'b0;
         port_bank_index <= 3'h0;
      end else begin
         port_bank_hit <= acc.req && acc.addr >= PORT_FIRST && acc.addr <= PORT_LAST;
         port_bank_index <= 3'(acc.addr[9:PORT_BANK_LSB] - 3'h2);
      end
   end

   // outputs toward the rest of the controller
   assign host_irq              = gc_irq_en && (pend != 7'h00);
   assign advanced_mode_on      = gc_adv;
   assign controller_soft_reset = gc_soft_rst;
   assign msi_single_fallback   = gc_msi_single_fallback;
   assign auto_link_power_en    = feat_word[FEAT_ALP] && gc_adv;
   assign list_override_en      = feat_word[FEAT_CLO];
   assign ports_implemented     = pi_bits;
   assign coalesce_enable       = coalescing_control[0];
   assign coalesce_ports        = coalescing_port_select;
endmodule : ahgc_host_control

// ==== ahgc_checker.sv ====
`timescale 1ns/1ps
// protocol and side-output checks on the generic host control bank
module ahgc_checker (
   input wire logic                clk,
   input wire logic                sys_rst,
   input wire logic                platform_reset_n,
   input wire ahgc_pkg::ahgc_acc_t acc,
   input wire ahgc_pkg::ahgc_rsp_t rsp,
   input wire logic                msi_on,
   input wire logic [2:0]          msi_granted_count,
   input wire logic [2:0]          msi_requested_count,
   input wire logic                advanced_mode_on,
   input wire logic                controller_soft_reset,
   input wire logic                msi_single_fallback,
   input wire logic                auto_link_power_en,
   input wire logic                port_bank_hit,
   input wire logic [2:0]          port_bank_index
);
   import ahgc_pkg::*;
   // vector shortage condition seen from config space
   wire logic short_v = msi_on && (msi_granted_count != 3'h0)
                        && (msi_granted_count < msi_requested_count);
   // write of one to the controller reset bit
   wire logic hr_wr = acc.req && acc.wr && acc.be[0] && (acc.addr == OFS_GCTRL)
                      && acc.wdata[GC_SOFT_RST];
   wire logic rd_q  = acc.req && !acc.wr;  // read request
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst || !platform_reset_n);
   a_ack_after_req: assert property (acc.req |=> rsp.ack)
      else $error("ack missing after request");
   a_ack_has_cause: assert property (rsp.ack |-> $past(acc.req))
      else $error("ack without request");
   a_gap_reads_zero: assert property (rd_q && acc.addr > OFS_EM_CTL && acc.addr < PORT_FIRST
      |=> rsp.rdata == ZERO_WORD)
      else $error("reserved read not zero");
   a_bank_decode: assert property (acc.req && acc.addr >= PORT_FIRST |=> port_bank_hit
      && port_bank_index == $past(acc.addr[9:7]) - 3'h2)
      else $error("port bank decode wrong");
   a_feat_fixed: assert property (rd_q && acc.addr == OFS_FEATURE |=> rsp.rdata[12:8] == NCS_CODE
      && rsp.rdata[4:0] == NPS_CODE && rsp.rdata[31:30] == 2'b11 && !rsp.rdata[18])
      else $error("feature fixed fields wrong");
   a_hr_pulse: assert property (hr_wr |=> controller_soft_reset ##1 !controller_soft_reset)
      else $error("controller reset pulse wrong");
   a_hr_cause: assert property ($rose(controller_soft_reset) |-> $past(hr_wr))
      else $error("controller reset without write");
   a_fallback_set: assert property ((short_v && !controller_soft_reset) [*2]
      |-> msi_single_fallback)
      else $error("fallback flag not set");
   a_fallback_clr: assert property ((!short_v) [*2] |-> !msi_single_fallback)
      else $error("fallback flag not cleared");
   a_alp_gated: assert property (auto_link_power_en |-> advanced_mode_on)
      else $error("link power enable without mode");
   c_soft_reset: cover property (hr_wr ##1 controller_soft_reset);
   c_bank_hit:   cover property (port_bank_hit);
   c_fallback:   cover property ($rose(msi_single_fallback));
endmodule : ahgc_checker

bind ahgc_host_control ahgc_checker chk_u (.clk(clk), .sys_rst(sys_rst),
   .platform_reset_n(platform_reset_n), .acc(acc), .rsp(rsp), .msi_on(msi_on),
   .msi_granted_count(msi_granted_count), .msi_requested_count(msi_requested_count),
   .advanced_mode_on(advanced_mode_on), .controller_soft_reset(controller_soft_reset),
   .msi_single_fallback(msi_single_fallback), .auto_link_power_en(auto_link_power_en),
   .port_bank_hit(port_bank_hit), .port_bank_index(port_bank_index));

// ==== ahgc_host_model.sv ====
`timescale 1ns/1ps
// host software side: single aligned word accesses, one strobe each
module ahgc_host_model (
   input  wire logic                clk,
   output      ahgc_pkg::ahgc_acc_t acc,
   input  wire ahgc_pkg::ahgc_rsp_t rsp
);
   import ahgc_pkg::*;
   initial acc = '0;
   // one access; read data is unknown when no ack arrives
   task automatic access(input logic wr, input logic [9:0] addr, input logic [31:0] wdata,
                         output logic [31:0] rdata);
      int n;
      rdata = 'x;
      @(posedge clk);
      #1 acc = '{req:1'b1, wr:wr, addr:addr, be:4'hf, wdata:wdata};
      @(posedge clk);
      #1 acc.req = 1'b0;
      for (n = 0; n < 4; n++) begin
         @(posedge clk);
         if (rsp.ack === 1'b1) begin
            rdata = rsp.rdata;
            break;
         end
      end
   endtask : access
endmodule : ahgc_host_model

// ==== tb_top.sv ====
`timescale 1ns/1ps
// register sequences against the generic host control bank
module tb_top;
   import ahgc_pkg::*;
   // feature reset image with the hard port count field in bits 4:0
   localparam logic [31:0] FEAT_EXP = {FEAT_RST_DESK[31:5], NPS_CODE};
   logic clk = 0, sys_rst = 1, platform_reset_n = 0, coalesce_event = 0, msi_on = 0;
   logic [5:0]  port_irq_event = 6'h00;
   logic [2:0]  msi_granted_count = 3'h0, msi_requested_count = 3'h0;
   logic [31:0] d;
   ahgc_acc_t   acc;
   ahgc_rsp_t   rsp;
   logic host_irq, advanced_mode_on, controller_soft_reset, msi_single_fallback;
   logic auto_link_power_en, list_override_en, coalesce_enable, port_bank_hit;
   logic [5:0]  ports_implemented;
   logic [31:0] coalesce_ports;
   logic [2:0]  port_bank_index;
   int fail_count = 0, cmp_count = 0;
   ahgc_host_control dut_u (.clk(clk), .sys_rst(sys_rst), .platform_reset_n(platform_reset_n),
      .acc(acc), .rsp(rsp), .port_irq_event(port_irq_event), .coalesce_event(coalesce_event),
      .msi_on(msi_on), .msi_granted_count(msi_granted_count),
      .msi_requested_count(msi_requested_count), .host_irq(host_irq),
      .advanced_mode_on(advanced_mode_on), .controller_soft_reset(controller_soft_reset),
      .msi_single_fallback(msi_single_fallback), .auto_link_power_en(auto_link_power_en),
      .list_override_en(list_override_en), .ports_implemented(ports_implemented),
      .coalesce_enable(coalesce_enable), .coalesce_ports(coalesce_ports),
      .port_bank_hit(port_bank_hit), .port_bank_index(port_bank_index));
   ahgc_host_model host_u (.clk(clk), .acc(acc), .rsp(rsp));
   initial forever #12.5 clk = ~clk;
   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [9:0] a, input logic [31:0] v);
      host_u.access(1'b1, a, v, d);
   endtask : wr
   task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp);
      host_u.access(1'b0, a, 32'h00000000, d);
      chk(d, exp);
   endtask : rd_chk
   task automatic final_report;
      $display("checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : final_report
   initial begin
      #(25 * 20000);
      fail_count++;
      final_report();
   end
   initial begin
      repeat (4) @(posedge clk);
      #1 {sys_rst, platform_reset_n} = 2'b01;
      rd_chk(OFS_FEATURE, FEAT_EXP);
      wr(OFS_GCTRL, 32'h80000002);
      rd_chk(OFS_GCTRL, 32'h80000002);
      chk({30'h0, advanced_mode_on, auto_link_power_en}, 32'h3);
      wr(OFS_FEATURE, 32'h00000000);
      rd_chk(OFS_FEATURE, FEAT_EXP & ~FEAT_WO_MASK);
      chk({30'h0, list_override_en, auto_link_power_en}, 32'h0);
      wr(OFS_FEATURE, 32'hffffffff);
      rd_chk(OFS_FEATURE, FEAT_EXP & ~FEAT_WO_MASK);
      // events on ports 0 and 3 plus coalescing, one cycle each
      @(posedge clk);
      #1 {coalesce_event, port_irq_event} = 7'h49;
      @(posedge clk);
      #1 {coalesce_event, port_irq_event} = 7'h00;
      rd_chk(OFS_IRQ_STAT, 32'h00000049);
      chk({31'h0, host_irq}, 32'h1);
      wr(OFS_IRQ_STAT, 32'h00000000);
      rd_chk(OFS_IRQ_STAT, 32'h00000049);
      wr(OFS_IRQ_STAT, 32'h00000008);
      rd_chk(OFS_IRQ_STAT, 32'h00000041);
      wr(OFS_GCTRL, 32'h80000000);
      chk({31'h0, host_irq}, 32'h0);
      wr(OFS_GCTRL, 32'h80000001);
      rd_chk(OFS_GCTRL, 32'h80000000);
      rd_chk(OFS_IRQ_STAT, 32'h00000000);
      #1 {msi_on, msi_granted_count, msi_requested_count} = 7'h4b;
      rd_chk(OFS_GCTRL, 32'h80000004);
      #1 msi_granted_count = 3'h3;
      rd_chk(OFS_GCTRL, 32'h80000000);
      rd_chk(10'h040, ZERO_WORD);
      rd_chk(OFS_VENDOR, ZERO_WORD);
      rd_chk(OFS_VERSION, VERSION_VAL);
      rd_chk(OFS_ENCLOSURE_MSG_LOCATION, ENCLOSURE_MSG_LOCATION_VAL);
      // port 4 bank exists on every variant, unlike ports 2 and 3
      rd_chk(10'h300, ZERO_WORD);
      wr(OFS_COALESCING_PORT_SELECT, 32'h00000012);
      rd_chk(OFS_COALESCING_PORT_SELECT, 32'h00000012);
      chk(coalesce_ports, 32'h00000012);
      chk({31'h0, coalesce_enable}, {31'h0, COALESCING_CONTROL_RST[0]});
      wr(OFS_PORTS_IMP, 32'h0000003f);
      wr(OFS_PORTS_IMP, 32'h00000000);
      rd_chk(OFS_PORTS_IMP, 32'h0000003f);
      chk({26'h0, ports_implemented}, 32'h0000003f);
      @(posedge clk);
      #1 sys_rst = 1'b1;
      repeat (2) @(posedge clk);
      #1 sys_rst = 1'b0;
      rd_chk(OFS_FEATURE, FEAT_EXP & ~FEAT_WO_MASK);
      rd_chk(OFS_PORTS_IMP, 32'h0000003f);
      rd_chk(OFS_GCTRL, ZERO_WORD);
      rd_chk(OFS_COALESCING_PORT_SELECT, ZERO_WORD);
      rd_chk(OFS_COALESCING_CONTROL, COALESCING_CONTROL_RST);
      #1 platform_reset_n = 1'b0;
      repeat (2) @(posedge clk);
      #1 platform_reset_n = 1'b1;
      rd_chk(OFS_FEATURE, FEAT_EXP);
      rd_chk(OFS_PORTS_IMP, ZERO_WORD);
      final_report();
   end
endmodule : tb_top
